// ---- logic/tlos_transmit_line_output_stage.sv ----
`timescale 1ns/10ps
`default_nettype none

module tlos_transmit_line_output_stage (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        transmit_clock,
	input  wire logic        tx_mark_pos,
	input  wire logic        tx_mark_neg,
	input  wire logic        tx_nrz_data,
	input  wire logic        tx_frame_start,
	output logic             analog_tx_line_a,
	output logic             analog_tx_line_a_oe,
	output logic             analog_tx_line_b,
	output logic             analog_tx_line_b_oe,
	output logic             tx_rail_positive,
	output logic             tx_rail_positive_oe,
	output logic             tx_rail_negative,
	output logic             tx_rail_negative_oe,
	output logic             tx_optical_data,
	output logic             tx_optical_data_oe,
	output logic             tx_frame_marker,
	output logic             tx_frame_marker_oe
);

	logic [1:0] rst_sync_r;
	logic       rst_sync_n;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= tlos_pkg::TLOS_RST_SYNC_RESET;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_sync_n = rst_sync_r[1];

	// control register and apb read path
	logic [6:0]  ctrl_r;
	logic [6:0]  ctrl_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic [31:0] status_w;
	logic        map_hit;
	logic        fm_seen_r;
	logic        fm_seen_nxt;

	logic dlms;
	logic tcs;
	logic tri_st;
	logic fbs;
	logic pol;
	logic cmi_sel;
	logic rloop;
	tlos_pkg::tlos_mode_e mode;
	logic ana_en;
	logic dig_en;
	logic fm_en;
	logic [2:0] tclk_sync_r;
	logic [2:0] tclk_sync_nxt;
	logic       tclk_lvl_r;
	logic       tclk_lvl_nxt;
	logic       tclk_rise;
	logic       tclk_fall;
	logic       tclk_agree;

	assign dlms    = ctrl_r[tlos_pkg::TLOS_CTRL_DLMS];
	assign tcs     = ctrl_r[tlos_pkg::TLOS_CTRL_TCS];
	assign tri_st  = ctrl_r[tlos_pkg::TLOS_CTRL_TRI];
	assign fbs     = ctrl_r[tlos_pkg::TLOS_CTRL_FBS];
	assign pol     = ctrl_r[tlos_pkg::TLOS_CTRL_POL];
	assign cmi_sel = ctrl_r[tlos_pkg::TLOS_CTRL_CMI];
	assign rloop   = ctrl_r[tlos_pkg::TLOS_CTRL_RLOOP];

	always_comb begin
		if (dlms && tcs) begin
			mode = tlos_pkg::TLOS_MODE_DUAL;
		end else if (dlms) begin
			mode = tlos_pkg::TLOS_MODE_OPTICAL;
		end else begin
			mode = tlos_pkg::TLOS_MODE_ANALOG;
		end
	end

	assign ana_en = !dlms && tcs && !tri_st;
	assign dig_en = dlms && !tri_st;
	assign fm_en  = dig_en && !tcs;

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[tlos_pkg::TLOS_STAT_MODE_HI:tlos_pkg::TLOS_STAT_MODE_LO] =
			mode;
		status_w[tlos_pkg::TLOS_STAT_ANA_EN]  = ana_en;
		status_w[tlos_pkg::TLOS_STAT_DIG_EN]  = dig_en;
		status_w[tlos_pkg::TLOS_STAT_FM_EN]   = fm_en;
		status_w[tlos_pkg::TLOS_STAT_TCLK]    = tclk_lvl_r;
		status_w[tlos_pkg::TLOS_STAT_FM_SEEN] = fm_seen_r;
	end

	assign map_hit = (paddr == tlos_pkg::TLOS_ADDR_CTRL) ||
		(paddr == tlos_pkg::TLOS_ADDR_STATUS);

	// no wait states: read data is captured in the setup cycle
	assign pready  = psel && penable;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	always_comb begin
		ctrl_nxt    = ctrl_r;
		prdata_nxt  = prdata_r;
		pslverr_nxt = pslverr_r;
		fm_seen_nxt = fm_seen_r;
		if (psel && !penable) begin
			pslverr_nxt = !map_hit;
			prdata_nxt  = 32'h0000_0000;
			if (!pwrite && paddr == tlos_pkg::TLOS_ADDR_CTRL) begin
				prdata_nxt[6:0] = ctrl_r;
			end else if (!pwrite && paddr == tlos_pkg::TLOS_ADDR_STATUS) begin
				prdata_nxt = status_w;
			end
		end
		if (psel && penable && pwrite &&
			paddr == tlos_pkg::TLOS_ADDR_CTRL) begin
			ctrl_nxt = pwdata[6:0];
		end
		// reading status clears the sticky marker flag; a new marker wins
		if (psel && penable && !pwrite &&
			paddr == tlos_pkg::TLOS_ADDR_STATUS) begin
			fm_seen_nxt = 1'b0;
		end
		if (tclk_rise && tx_frame_start && fm_en) begin
			fm_seen_nxt = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_r    <= tlos_pkg::TLOS_CTRL_RESET;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			fm_seen_r <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			fm_seen_r <= fm_seen_nxt;
		end
	end

	// transmit clock pin: three flops, edge counts when last two agree
	assign tclk_sync_nxt = {tclk_sync_r[1:0], transmit_clock};
	assign tclk_agree = (tclk_sync_r[1] == tclk_sync_r[2]);
	assign tclk_rise  = tclk_agree && tclk_sync_r[2] && !tclk_lvl_r;
	assign tclk_fall  = tclk_agree && !tclk_sync_r[2] && tclk_lvl_r;
	assign tclk_lvl_nxt = tclk_agree ? tclk_sync_r[2] : tclk_lvl_r;

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tclk_sync_r <= tlos_pkg::TLOS_SYNC_RESET;
			tclk_lvl_r  <= 1'b0;
		end else begin
			tclk_sync_r <= tclk_sync_nxt;
			tclk_lvl_r  <= tclk_lvl_nxt;
		end
	end

	// line state; rail and optical pin levels are stored after polarity
	logic ana_a_r;
	logic ana_a_nxt;
	logic ana_b_r;
	logic ana_b_nxt;
	logic rail_p_r;
	logic rail_p_nxt;
	logic rail_n_r;
	logic rail_n_nxt;
	logic opt_r;
	logic opt_nxt;
	logic cmi_lvl_r;
	logic cmi_lvl_nxt;
	logic cmi_bit_r;
	logic cmi_bit_nxt;
	logic fm_r;
	logic fm_nxt;
	logic rail_idle;

	// rails active low when polarity bit clear
	assign rail_idle = !pol;

	always_comb begin
		ana_a_nxt   = ana_a_r;
		ana_b_nxt   = ana_b_r;
		rail_p_nxt  = rail_p_r;
		rail_n_nxt  = rail_n_r;
		opt_nxt     = opt_r;
		cmi_lvl_nxt = cmi_lvl_r;
		cmi_bit_nxt = cmi_bit_r;
		fm_nxt      = fm_r;
		if (tclk_rise) begin
			ana_a_nxt  = tx_mark_pos;
			ana_b_nxt  = tx_mark_neg;
			rail_p_nxt = tx_mark_pos ? !rail_idle : rail_idle;
			rail_n_nxt = tx_mark_neg ? !rail_idle : rail_idle;
			fm_nxt = tx_frame_start && !rloop;
			cmi_bit_nxt = tx_nrz_data;
			if (cmi_sel) begin
				if (tx_nrz_data) begin
					cmi_lvl_nxt = !cmi_lvl_r;
					opt_nxt     = !cmi_lvl_r ^ pol;
				end else begin
					opt_nxt = pol;
				end
			end else begin
				opt_nxt = tx_nrz_data ^ pol;
			end
		end else if (tclk_fall) begin
			if (!fbs) begin
				ana_a_nxt  = 1'b0;
				ana_b_nxt  = 1'b0;
				rail_p_nxt = rail_idle;
				rail_n_nxt = rail_idle;
			end
			if (cmi_sel && !cmi_bit_r) begin
				opt_nxt = !pol;
			end
		end
	end

	// analog pair and optical idle low; rails idle at inactive level
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ana_a_r   <= 1'b0;
			ana_b_r   <= 1'b0;
			rail_p_r  <= 1'b1;
			rail_n_r  <= 1'b1;
			opt_r     <= 1'b0;
			cmi_lvl_r <= 1'b0;
			cmi_bit_r <= 1'b0;
			fm_r      <= 1'b0;
		end else begin
			ana_a_r   <= ana_a_nxt;
			ana_b_r   <= ana_b_nxt;
			rail_p_r  <= rail_p_nxt;
			rail_n_r  <= rail_n_nxt;
			opt_r     <= opt_nxt;
			cmi_lvl_r <= cmi_lvl_nxt;
			cmi_bit_r <= cmi_bit_nxt;
			fm_r      <= fm_nxt;
		end
	end

	assign analog_tx_line_a    = ana_a_r;
	assign analog_tx_line_b    = ana_b_r;
	assign analog_tx_line_a_oe = ana_en;
	assign analog_tx_line_b_oe = ana_en;

	assign tx_rail_positive = rail_p_r;
	assign tx_rail_negative = rail_n_r;
	assign tx_rail_positive_oe = dig_en && tcs;
	assign tx_rail_negative_oe = dig_en && tcs;

	assign tx_optical_data = opt_r;
	assign tx_optical_data_oe = dig_en && !tcs;

	assign tx_frame_marker = fm_r;
	assign tx_frame_marker_oe = fm_en;

endmodule : tlos_transmit_line_output_stage

`default_nettype wire

// ---- logic/tlos_pkg.sv ----
package tlos_pkg;

	// line modes of the transmit output stage
	typedef enum logic [1:0] {
		TLOS_MODE_ANALOG  = 2'b00,
		TLOS_MODE_DUAL    = 2'b01,
		TLOS_MODE_OPTICAL = 2'b10,
		TLOS_MODE_RSVD    = 2'b11
	} tlos_mode_e;

	localparam int unsigned TLOS_ADDR_W = 12;
	localparam int unsigned TLOS_DATA_W = 32;

	// register byte addresses
	localparam logic [11:0] TLOS_ADDR_CTRL   = 12'h000;
	localparam logic [11:0] TLOS_ADDR_STATUS = 12'h004;

	// control register bit positions
	localparam int unsigned TLOS_CTRL_DLMS  = 0;
	localparam int unsigned TLOS_CTRL_TCS   = 1;
	localparam int unsigned TLOS_CTRL_TRI   = 2;
	localparam int unsigned TLOS_CTRL_FBS   = 3;
	localparam int unsigned TLOS_CTRL_POL   = 4;
	localparam int unsigned TLOS_CTRL_CMI   = 5;
	localparam int unsigned TLOS_CTRL_RLOOP = 6;
	localparam int unsigned TLOS_CTRL_W     = 7;

	// control value after reset: tristate set, everything else clear
	localparam logic [6:0] TLOS_CTRL_RESET = 7'h04;

	// status register bit positions
	localparam int unsigned TLOS_STAT_MODE_LO = 0;
	localparam int unsigned TLOS_STAT_MODE_HI = 1;
	localparam int unsigned TLOS_STAT_ANA_EN  = 2;
	localparam int unsigned TLOS_STAT_DIG_EN  = 3;
	localparam int unsigned TLOS_STAT_FM_EN   = 4;
	localparam int unsigned TLOS_STAT_TCLK    = 5;
	localparam int unsigned TLOS_STAT_FM_SEEN = 6;

	// synchroniser depth for the transmit clock pin
	localparam int unsigned TLOS_SYNC_STAGES = 3;

	// reset values of the synchroniser flops
	localparam logic [2:0] TLOS_SYNC_RESET = 3'h0;
	localparam logic [1:0] TLOS_RST_SYNC_RESET = 2'h0;

endpackage : tlos_pkg

// ---- tb/tlos_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module tlos_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic transmit_clock,
	input wire logic tx_frame_start,
	input wire logic analog_tx_line_a_oe,
	input wire logic analog_tx_line_b_oe,
	input wire logic tx_rail_positive,
	input wire logic tx_rail_positive_oe,
	input wire logic tx_rail_negative,
	input wire logic tx_rail_negative_oe,
	input wire logic tx_optical_data,
	input wire logic tx_optical_data_oe,
	input wire logic tx_frame_marker,
	input wire logic tx_frame_marker_oe
);
	logic       tclk_r;
	logic [3:0] age_r;
	logic [3:0] age_nxt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// cycles since the pin last moved, saturating
	always_comb begin
		age_nxt = age_r + {3'h0, age_r != 4'hf};
		if (transmit_clock != tclk_r) age_nxt = 4'h0;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tclk_r <= 1'b0;
			age_r  <= 4'h0;
		end else begin
			tclk_r <= transmit_clock;
			age_r  <= age_nxt;
		end
	end
	property p_ana_pair; analog_tx_line_a_oe == analog_tx_line_b_oe;
	endproperty
	a_ana_pair: assert property (p_ana_pair)
		else $error("analog enables differ");
	property p_ana_excl;
		analog_tx_line_a_oe |-> !tx_rail_positive_oe && !tx_optical_data_oe;
	endproperty
	a_ana_excl: assert property (p_ana_excl)
		else $error("analog and digital both driven");
	property p_rail_pair; tx_rail_positive_oe == tx_rail_negative_oe;
	endproperty
	a_rail_pair: assert property (p_rail_pair)
		else $error("rail enables differ");
	property p_opt_excl; tx_optical_data_oe |-> !tx_rail_positive_oe;
	endproperty
	a_opt_excl: assert property (p_opt_excl)
		else $error("optical and rails both driven");
	property p_fm_opt; tx_frame_marker_oe == tx_optical_data_oe;
	endproperty
	a_fm_opt: assert property (p_fm_opt)
		else $error("marker enable outside optical mode");
	property p_oe_rst; $rose(rst_n) |->
		!(tx_rail_positive_oe || tx_optical_data_oe || tx_frame_marker_oe) [*3];
	endproperty
	a_oe_rst: assert property (p_oe_rst)
		else $error("digital output driven after reset");
	property p_rail_launch;
		$changed(tx_rail_positive) || $changed(tx_rail_negative) |-> age_r <= 4'h6;
	endproperty
	a_rail_launch: assert property (p_rail_launch)
		else $error("rail moved without a line edge");
	property p_opt_launch; $changed(tx_optical_data) |-> age_r <= 4'h6;
	endproperty
	a_opt_launch: assert property (p_opt_launch)
		else $error("optical moved without a line edge");
	// marker may only move shortly after a rise
	property p_fm_launch;
		$changed(tx_frame_marker) |-> age_r <= 4'h6 && transmit_clock;
	endproperty
	a_fm_launch: assert property (p_fm_launch)
		else $error("marker moved off a rising edge");
	property p_fm_start; $rose(tx_frame_marker) |-> tx_frame_start;
	endproperty
	a_fm_start: assert property (p_fm_start)
		else $error("marker without frame start");
	c_rail: cover property ($rose(tx_rail_positive_oe));
	c_opt: cover property ($rose(tx_optical_data_oe));
	c_fm: cover property ($rose(tx_frame_marker));
endmodule : tlos_asserts
bind tlos_transmit_line_output_stage tlos_asserts u_chk (.mclk, .rst_n,
	.transmit_clock, .tx_frame_start, .analog_tx_line_a_oe,
	.analog_tx_line_b_oe, .tx_rail_positive, .tx_rail_positive_oe,
	.tx_rail_negative, .tx_rail_negative_oe, .tx_optical_data,
	.tx_optical_data_oe, .tx_frame_marker, .tx_frame_marker_oe);
`default_nettype wire

// ---- tb/tlos_framer_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tlos_framer_model #(
	parameter int FRAME_BITS = 8
) (
	output var logic transmit_clock,
	output var logic tx_mark_pos,
	output var logic tx_mark_neg,
	output var logic tx_nrz_data,
	output var logic tx_frame_start
);
	logic [2:0] m;
	int         cnt;
	initial begin
		transmit_clock = 1'b0;
		{tx_mark_pos, tx_mark_neg, tx_nrz_data, tx_frame_start} = 4'h0;
		cnt = 0;
	end
	// free running, edges coincide with mclk falling edges
	always #40 transmit_clock = ~transmit_clock;
	always @(negedge transmit_clock) begin
		m = 3'($urandom);
		tx_mark_pos <= m[0];
		tx_mark_neg <= m[1] & ~m[0];
		tx_nrz_data <= m[2];
		tx_frame_start <= (cnt == 0);
		cnt <= (cnt + 1) % FRAME_BITS;
	end
endmodule : tlos_framer_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        transmit_clock, tx_mark_pos, tx_mark_neg;
	logic        tx_nrz_data, tx_frame_start;
	logic        analog_tx_line_a, analog_tx_line_a_oe;
	logic        analog_tx_line_b, analog_tx_line_b_oe;
	logic        tx_rail_positive, tx_rail_positive_oe;
	logic        tx_rail_negative, tx_rail_negative_oe;
	logic        tx_optical_data, tx_optical_data_oe;
	logic        tx_frame_marker, tx_frame_marker_oe;
	logic [6:0]  c;
	int          bad_count, checks;
	tlos_transmit_line_output_stage dut (.mclk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.transmit_clock, .tx_mark_pos, .tx_mark_neg, .tx_nrz_data,
		.tx_frame_start, .analog_tx_line_a, .analog_tx_line_a_oe,
		.analog_tx_line_b, .analog_tx_line_b_oe, .tx_rail_positive,
		.tx_rail_positive_oe, .tx_rail_negative, .tx_rail_negative_oe,
		.tx_optical_data, .tx_optical_data_oe, .tx_frame_marker,
		.tx_frame_marker_oe);
	tlos_framer_model u_fr (.transmit_clock, .tx_mark_pos, .tx_mark_neg,
		.tx_nrz_data, .tx_frame_start);
	always #2 mclk = ~mclk;
	task close_out;
		$display("mismatches %0d checks %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task chk(input logic g, input logic x);
		checks++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch at %0t: got %b want %b", $time, g, x);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// first half h=1; half baud returns to idle after
	function logic rail(logic m, logic h);
		return (m & (h | c[3])) ^ ~c[4];
	endfunction : rail
	// expected status: mode, analog, digital and marker enables
	function logic [4:0] st(logic [6:0] v);
		logic [1:0] m;
		m = v[0] ? (v[1] ? 2'h1 : 2'h2) : 2'h0;
		return {v[0] & ~v[1] & ~v[2], v[0] & ~v[2], ~v[0] & v[1] & ~v[2], m};
	endfunction : st
	task watch;
		logic [3:0] s;
		logic lv, ok;
		ok = 1'b0;
		lv = 1'b0;
		repeat (2) @(posedge transmit_clock);
		repeat (16) begin
			@(posedge transmit_clock);
			s = {tx_frame_start, tx_nrz_data, tx_mark_neg, tx_mark_pos};
			@(negedge transmit_clock);
			if (c[1]) begin
				chk(tx_rail_positive, rail(s[0], 1'b1));
				chk(tx_rail_negative, rail(s[1], 1'b1));
				chk(analog_tx_line_a, s[0]);
				chk(analog_tx_line_b, s[1]);
			end else begin
				chk(tx_frame_marker, s[3] & ~c[6]);
				if (!c[5]) chk(tx_optical_data, s[2] ^ c[4]);
				else if (!s[2]) chk(tx_optical_data, c[4]);
				else if (ok) chk(tx_optical_data ^ c[4], ~lv);
				if (c[5] && s[2]) {ok, lv} = {1'b1, tx_optical_data ^ c[4]};
			end
			#35;
			if (c[1]) begin
				chk(tx_rail_positive, rail(s[0], 1'b0));
				chk(tx_rail_negative, rail(s[1], 1'b0));
				chk(analog_tx_line_a, s[0] & c[3]);
				chk(analog_tx_line_b, s[1] & c[3]);
			end else begin
				chk(tx_optical_data, (c[5] ? (~s[2] | lv) : s[2]) ^ c[4]);
				chk(tx_frame_marker, s[3] & ~c[6]);
			end
		end
	endtask : watch
	// awkward cases: polarities, bauds, cmi, remote loop, analog
	logic [6:0] cfg [12] = '{7'h03, 7'h0b, 7'h13, 7'h1b, 7'h01,
		7'h11, 7'h21, 7'h31, 7'h41, 7'h61, 7'h02, 7'h0a};
	initial begin
		{mclk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{bad_count, checks} = '0;
		void'($urandom(23923));
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk(tx_rail_positive_oe | tx_optical_data_oe, 1'b0);
		chk(analog_tx_line_a_oe | tx_frame_marker_oe, 1'b0);
		chk(tx_rail_positive & ~tx_optical_data, 1'b1);
		apb(1'b0, tlos_pkg::TLOS_ADDR_CTRL, 32'h0);
		chk(r === {25'h0, tlos_pkg::TLOS_CTRL_RESET}, 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		chk(e && r === 32'h0, 1'b1);
		repeat (40) begin
			c = 7'($urandom);
			apb(1'b1, tlos_pkg::TLOS_ADDR_CTRL, {25'h0, c});
			apb(1'b0, tlos_pkg::TLOS_ADDR_CTRL, 32'h0);
			chk(r === {25'h0, c} && !e, 1'b1);
			chk(analog_tx_line_a_oe, !c[0] && c[1] && !c[2]);
			chk(tx_rail_negative_oe, c[0] && c[1] && !c[2]);
			chk(tx_optical_data_oe, c[0] && !c[1] && !c[2]);
			chk(tx_frame_marker_oe, c[0] && !c[1] && !c[2]);
			apb(1'b0, tlos_pkg::TLOS_ADDR_STATUS, 32'h0);
			chk(r[4:0] === st(c) && !e, 1'b1);
		end
		foreach (cfg[i]) begin
			c = cfg[i];
			apb(1'b1, tlos_pkg::TLOS_ADDR_CTRL, {25'h0, c});
			watch;
			apb(1'b0, tlos_pkg::TLOS_ADDR_STATUS, 32'h0);
			chk(r[4:0] === st(c), 1'b1);
			if (c[0] && !c[1]) chk(r[6], 1'b1);
		end
		close_out;
	end
	// about 20 us of traffic expected
	initial begin
		#100000;
		bad_count++;
		close_out;
	end
endmodule : tb_top
`default_nettype wire
